// ==== rtl/tc4_ctrl.v ====
// Timer/counter 4 control, compare registers, counter and APB slave
//
// Contract
// - One control and two 8-bit compare registers, read/write, compares reset to ones.
// - Control holds flip-flop bit 7, clock 6:4, run 3, mode 2:0.
// - Flip-flop control 0 gives a cleared output, 1 a set output.
// - Clock codes pick prescaler taps, low clock or pin; low speed limits.
// - Run 0 halts and clears the counter; run 1 starts the selected mode.
// - Mode codes select timer, divider, PWM, 16-bit, warm-up, 16-bit PWM.
// - Mode top bit set: count the first timer overflow, ignore own clock.
// - 16-bit clock from first timer select; run and flip-flop from here.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "tc4_regs.vh"
module tc4_ctrl
(
   // Clock, reset, enable
   input  wire       I_REF_CLK,
   input  wire       I_RSTN,
   input  wire       I_CE,
   // APB slave
   input  wire       I_PSEL,
   input  wire       I_PENABLE,
   input  wire       I_PWRITE,
   input  wire [9:0] I_PADDR,
   input  wire [31:0] I_PWDATA,
   output wire       O_PREADY,
   output reg  [31:0] O_PRDATA,
   output wire       O_PSLVERR,
   // Asynchronous pins
   input  wire       I_LOW_FREQ_CLK,
   input  wire       I_COUNT_PIN,
   // First timer, same clock domain
   input  wire [2:0] I_FIRST_CLOCK_SELECT,
   input  wire       I_FIRST_OVERFLOW,
   input  wire [7:0] I_FIRST_COUNT,
   input  wire [7:0] I_FIRST_PERIOD,
   input  wire [7:0] I_FIRST_DUTY,
   output wire       O_CASCADE_TICK,
   output reg        O_FIRST_CLEAR,
   output wire       O_MODE16,
   // Timer output and interrupt
   output reg        O_TIMER_FF,
   output wire       O_IRQ
);
   reg  [7:0]  ctrl_q;
   reg  [7:0]  period_q;
   reg  [7:0]  duty_q;
   reg  [7:0]  cnt_q;
   reg  [1:0]  status_q;
   reg  [1:0]  mask_q;
   reg  [1:0]  option_q;
   reg  [1:0]  rd_snap_q;
   reg  [2:0]  lf_sync_q;
   reg  [2:0]  pin_sync_q;
   reg  [7:0]  cnt_d;
   reg         ff_d;
   reg         clr_first_d;
   reg  [1:0]  evt;
   reg  [31:0] rdata;
   reg         hit;
   wire [7:0]  idx;
   wire        aligned;
   wire        setup;
   wire        access;
   wire        wr;
   wire        run;
   wire        ffctl;
   wire [2:0]  mode;
   wire [2:0]  own_ck;
   wire        mode16;
   wire [2:0]  tick_code;
   wire        sel_tick;
   wire        own_tick;
   wire [15:0] cnt16;
   wire [15:0] period16;
   wire [15:0] duty16;

   // Field views of the control register
   assign ffctl  = ctrl_q[`TC4_CTRL_FF];
   assign own_ck = ctrl_q[`TC4_CTRL_CK_HI:`TC4_CTRL_CK_LO];
   assign run    = ctrl_q[`TC4_CTRL_RUN];
   assign mode   = ctrl_q[`TC4_CTRL_MODE_HI:`TC4_CTRL_MODE_LO];
   assign mode16 = mode[2];
   assign O_MODE16 = mode16;

   // Pairing of first timer as low byte and this unit as high byte
   assign cnt16    = {cnt_q, I_FIRST_COUNT};
   assign period16 = {period_q, I_FIRST_PERIOD};
   assign duty16   = {duty_q, I_FIRST_DUTY};

   // Pin synchronisers; only the later stages feed edge detection
   always @(posedge I_REF_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         lf_sync_q  <= 3'h0;
         pin_sync_q <= 3'h0;
      end
      else if (I_CE)
      begin
         lf_sync_q  <= {lf_sync_q[1:0], I_LOW_FREQ_CLK};
         pin_sync_q <= {pin_sync_q[1:0], I_COUNT_PIN};
      end
   end

   // Cascade takes the first timer clock code, else our own
   assign tick_code = mode16 ? I_FIRST_CLOCK_SELECT : own_ck;

   tc4_tick_sel u_tick_sel
   (
      .clk        (I_REF_CLK),
      .rst_n      (I_RSTN),
      .ce         (I_CE),
      .lf_edge    (lf_sync_q[1] & ~lf_sync_q[2]),
      .pin_edge   (pin_sync_q[1] & ~pin_sync_q[2]),
      .code       (tick_code),
      .div_ls_opt (option_q[`TC4_OPT_DIVLS]),
      .low_speed  (option_q[`TC4_OPT_LOWSPEED]),
      .tick       (sel_tick)
   );

   // Low byte ticks only while this unit runs the cascade
   assign O_CASCADE_TICK = mode16 & run & sel_tick;
   // Own clock ignored in 16-bit modes: first timer overflow drives us
   assign own_tick = mode16 ? I_FIRST_OVERFLOW : sel_tick;

   // Counting and flip-flop behaviour per mode
   always @*
   begin
      cnt_d       = cnt_q;
      ff_d        = O_TIMER_FF;
      clr_first_d = 1'b0;
      evt         = 2'h0;
      if (!run)
      begin
         cnt_d = 8'h00;
         ff_d  = ffctl;
      end
      else
      begin
         case (mode)
            `TC4_MODE_TIMER8, `TC4_MODE_DIVOUT8 :
            begin
               if (own_tick)
               begin
                  if (cnt_q == period_q)
                  begin
                     cnt_d = 8'h00;
                     evt[`TC4_ST_MATCH] = 1'b1;
                     if (mode == `TC4_MODE_DIVOUT8)
                        ff_d = ~O_TIMER_FF;
                  end
                  else
                     cnt_d = cnt_q + 8'h01;
               end
            end
            `TC4_MODE_PWM8 :
            begin
               if (own_tick)
               begin
                  cnt_d = cnt_q + 8'h01;
                  if (cnt_q == duty_q)
                  begin
                     ff_d = ~O_TIMER_FF;
                     evt[`TC4_ST_MATCH] = 1'b1;
                  end
                  if (cnt_q == 8'hff)
                  begin
                     ff_d = ffctl;
                     evt[`TC4_ST_OVF] = 1'b1;
                  end
               end
            end
            `TC4_MODE_TIMER16, `TC4_MODE_WARMUP :
            begin
               // Match checked on the low byte tick, both bytes cleared
               if (O_CASCADE_TICK && cnt16 == period16)
               begin
                  cnt_d       = 8'h00;
                  clr_first_d = 1'b1;
                  evt[`TC4_ST_MATCH] = 1'b1;
               end
               else if (own_tick)
                  cnt_d = cnt_q + 8'h01;
            end
            `TC4_MODE_PWM16 :
            begin
               if (own_tick)
                  cnt_d = cnt_q + 8'h01;
               if (O_CASCADE_TICK && cnt16 == duty16)
               begin
                  ff_d = ~O_TIMER_FF;
                  evt[`TC4_ST_MATCH] = 1'b1;
               end
               if (O_CASCADE_TICK && cnt16 == 16'hffff)
               begin
                  ff_d = ffctl;
                  evt[`TC4_ST_OVF] = 1'b1;
               end
            end
            default :
               cnt_d = 8'h00;
         endcase
      end
   end

   // Counter state
   always @(posedge I_REF_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         cnt_q         <= 8'h00;
         O_TIMER_FF    <= 1'b0;
         O_FIRST_CLEAR <= 1'b0;
      end
      else if (I_CE)
      begin
         cnt_q         <= cnt_d;
         O_TIMER_FF    <= ff_d;
         O_FIRST_CLEAR <= clr_first_d;
      end
   end

   // APB decode: register index is the word address
   assign idx     = I_PADDR[9:2];
   assign aligned = (I_PADDR[1:0] == 2'h0);
   assign setup   = I_PSEL & ~I_PENABLE;
   assign access  = I_PSEL & I_PENABLE;
   assign wr      = access & I_PWRITE & hit;
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = access & ~hit;

   // Read mux, also flags mapped addresses
   always @*
   begin
      rdata = 32'h0000_0000;
      hit   = aligned;
      case (idx)
         `TC4_IDX_CTRL   : rdata[7:0] = ctrl_q;
         `TC4_IDX_PERIOD : rdata[7:0] = period_q;
         `TC4_IDX_DUTY   : rdata[7:0] = duty_q;
         `TC4_IDX_STATUS : rdata[1:0] = status_q;
         `TC4_IDX_MASK   : rdata[1:0] = mask_q;
         `TC4_IDX_OPTION : rdata[1:0] = option_q;
         `TC4_IDX_COUNT  : rdata[7:0] = cnt_q;
         default         : hit = 1'b0;
      endcase
   end

   // Read data captured in setup so the access phase needs no wait state
   always @(posedge I_REF_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         O_PRDATA  <= 32'h0000_0000;
         rd_snap_q <= 2'h0;
      end
      else if (I_CE && setup)
      begin
         O_PRDATA  <= I_PWRITE ? 32'h0000_0000 : rdata;
         rd_snap_q <= (!I_PWRITE && hit && idx == `TC4_IDX_STATUS) ? status_q : 2'h0;
      end
   end

   // Register writes; no lockout while running, software keeps that discipline
   always @(posedge I_REF_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         ctrl_q   <= `TC4_RST_CTRL;
         period_q <= `TC4_RST_PERIOD;
         duty_q   <= `TC4_RST_DUTY;
         mask_q   <= `TC4_RST_MASK;
         option_q <= `TC4_RST_OPTION;
      end
      else if (I_CE && wr)
      begin
         case (idx)
            `TC4_IDX_CTRL   : ctrl_q   <= I_PWDATA[7:0];
            `TC4_IDX_PERIOD : period_q <= I_PWDATA[7:0];
            `TC4_IDX_DUTY   : duty_q   <= I_PWDATA[7:0];
            `TC4_IDX_MASK   : mask_q   <= I_PWDATA[1:0];
            `TC4_IDX_OPTION : option_q <= I_PWDATA[1:0];
            default         : ctrl_q   <= ctrl_q;
         endcase
      end
   end

   // Sticky events; read clears only the bits seen, a new event wins
   always @(posedge I_REF_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         status_q <= `TC4_RST_STATUS;
      else if (I_CE)
      begin
         if (access && !I_PWRITE)
            status_q <= (status_q & ~rd_snap_q) | evt;
         else
            status_q <= status_q | evt;
      end
   end

   assign O_IRQ = |(status_q & mask_q);
endmodule

// ==== rtl/tc4_regs.vh ====
// Register indices, field positions and reset values of timer/counter 4
`ifndef TC4_REGS_VH
`define TC4_REGS_VH
`define TC4_IDX_CTRL      8'h1b
`define TC4_IDX_PERIOD    8'h1d
`define TC4_IDX_DUTY      8'h1f
`define TC4_IDX_STATUS    8'h20
`define TC4_IDX_MASK      8'h21
`define TC4_IDX_OPTION    8'h22
`define TC4_IDX_COUNT     8'h23
`define TC4_RST_CTRL      8'h00
`define TC4_RST_PERIOD    8'hff
`define TC4_RST_DUTY      8'hff
`define TC4_RST_STATUS    2'h0
`define TC4_RST_MASK      2'h0
`define TC4_RST_OPTION    2'h0
`define TC4_CTRL_FF       7
`define TC4_CTRL_CK_HI    6
`define TC4_CTRL_CK_LO    4
`define TC4_CTRL_RUN      3
`define TC4_CTRL_MODE_HI  2
`define TC4_CTRL_MODE_LO  0
`define TC4_OPT_DIVLS     0
`define TC4_OPT_LOWSPEED  1
`define TC4_ST_MATCH      0
`define TC4_ST_OVF        1
`define TC4_CK_DIV2048    3'h0
`define TC4_CK_DIV128     3'h1
`define TC4_CK_DIV32      3'h2
`define TC4_CK_DIV8       3'h3
`define TC4_CK_LOWFREQ    3'h4
`define TC4_CK_DIV2       3'h5
`define TC4_CK_FULL       3'h6
`define TC4_CK_PIN        3'h7
`define TC4_MODE_TIMER8   3'h0
`define TC4_MODE_DIVOUT8  3'h1
`define TC4_MODE_PWM8     3'h2
`define TC4_MODE_RSVD     3'h3
`define TC4_MODE_TIMER16  3'h4
`define TC4_MODE_WARMUP   3'h5
`define TC4_MODE_PWM16    3'h6
`define TC4_PRE_BITS      11
`define TC4_LF_DIV_BITS   3
`endif

// ==== rtl/tc4_tick_sel.v ====
// Prescaler and count clock selection for timer/counter 4
`timescale 1ns/1ps
`include "tc4_regs.vh"
module tc4_tick_sel
(
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   input  wire       ce,
   // Sources, already synchronised edges
   input  wire       lf_edge,
   input  wire       pin_edge,
   // Selection
   input  wire [2:0] code,
   input  wire       div_ls_opt,
   input  wire       low_speed,
   // Selected count tick
   output reg        tick
);
   reg  [`TC4_PRE_BITS-1:0]    pre_q;
   reg  [`TC4_LF_DIV_BITS-1:0] lf_div_q;
   wire                        lf_div8;
   wire                        slow_tap;

   // Free prescaler on the high-frequency clock, and divide-by-8 of low-frequency edges
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_q    <= {`TC4_PRE_BITS{1'b0}};
         lf_div_q <= {`TC4_LF_DIV_BITS{1'b0}};
      end
      else if (ce)
      begin
         pre_q <= pre_q + 1'b1;
         if (lf_edge)
            lf_div_q <= lf_div_q + 1'b1;
      end
   end

   assign lf_div8  = lf_edge & (&lf_div_q);
   assign slow_tap = div_ls_opt | low_speed;

   // Tap select; low-speed operation leaves only three codes alive
   always @*
   begin
      tick = 1'b0;
      case (code)
         `TC4_CK_DIV2048 : tick = slow_tap ? lf_div8 : (&pre_q[10:0]);
         `TC4_CK_DIV128  : tick = ~low_speed & (&pre_q[6:0]);
         `TC4_CK_DIV32   : tick = ~low_speed & (&pre_q[4:0]);
         `TC4_CK_DIV8    : tick = ~low_speed & (&pre_q[2:0]);
         `TC4_CK_LOWFREQ : tick = lf_edge;
         `TC4_CK_DIV2    : tick = ~low_speed & pre_q[0];
         `TC4_CK_FULL    : tick = ~low_speed;
         `TC4_CK_PIN     : tick = pin_edge;
         default         : tick = 1'b0;
      endcase
   end
endmodule

// ==== bench/tc4_ctrl_monitor.sv ====
// Port-level checker for the timer/counter 4 control block
`timescale 1ns/1ps
module tc4_ctrl_monitor
(
   // Clock, reset, enable
   input wire        I_REF_CLK,
   input wire        I_RSTN,
   input wire        I_CE,
   // Register bus
   input wire        I_PSEL,
   input wire        I_PENABLE,
   input wire        I_PWRITE,
   input wire [9:0]  I_PADDR,
   input wire [31:0] I_PWDATA,
   input wire        O_PREADY,
   input wire        O_PSLVERR,
   // Cascade and outputs
   input wire        O_CASCADE_TICK,
   input wire        O_FIRST_CLEAR,
   input wire        O_MODE16,
   input wire        O_TIMER_FF,
   input wire        O_IRQ
);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RSTN);

   // Completed transfers, as the slave sees them
   wire acc = I_PSEL & I_PENABLE & I_CE;
   wire wr  = acc & I_PWRITE;
   wire ctl = wr & (I_PADDR == 10'h06c);
   wire mapped = (I_PADDR == 10'h06c) | (I_PADDR == 10'h074) | (I_PADDR == 10'h07c)
               | (I_PADDR == 10'h080) | (I_PADDR == 10'h084) | (I_PADDR == 10'h088)
               | (I_PADDR == 10'h08c);

   // Shadow of the mask, so the interrupt can be judged without peeking inside
   reg [1:0] mask_q;
   always @(posedge I_REF_CLK or negedge I_RSTN)
      if (!I_RSTN)
         mask_q <= 2'h0;
      else if (wr && I_PADDR == 10'h084)
         mask_q <= I_PWDATA[1:0];

   chk_ready_always:
      assert property (O_PREADY) else $error("pready low");
   chk_err_unmapped:
      assert property (acc && !mapped |-> O_PSLVERR) else $error("no error on hole");
   chk_err_mapped:
      assert property (acc && mapped |-> !O_PSLVERR) else $error("error on register");
   chk_mode_top:
      assert property (ctl |=> O_MODE16 == $past(I_PWDATA[2])) else $error("mode16 wrong");
   chk_ff_stopped:
      assert property (ctl && !I_PWDATA[3] |-> ##2 O_TIMER_FF == $past(I_PWDATA[7], 2))
         else $error("flip-flop not loaded");
   chk_tick_cascade:
      assert property (O_CASCADE_TICK |-> O_MODE16) else $error("cascade tick in 8-bit");
   chk_clear_after:
      assert property (O_FIRST_CLEAR |-> O_MODE16 && $past(O_CASCADE_TICK))
         else $error("first clear without tick");
   chk_irq_masked:
      assert property (mask_q == 2'h0 |-> !O_IRQ) else $error("masked interrupt seen");
endmodule

bind tc4_ctrl tc4_ctrl_monitor u_mon
(
   .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
   .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_CASCADE_TICK(O_CASCADE_TICK),
   .O_FIRST_CLEAR(O_FIRST_CLEAR), .O_MODE16(O_MODE16), .O_TIMER_FF(O_TIMER_FF),
   .O_IRQ(O_IRQ)
);

// ==== bench/tc4_ctrl_tb.sv ====
// Self-checking bench for the timer/counter 4 control block
`timescale 1ns/1ps
module tc4_ctrl_tb;
   logic        clk, rstn, ce, psel, penable, pwrite, lfclk, pin, fovf;
   logic        pready, pslverr, ctick, fclr, m16, tff, irq, err, ff0;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  fsel;
   logic [7:0]  fcnt, fper, fduty;
   int          fail_count, check_count;
   logic [9:0]  ra [7];
   logic [31:0] rw [7];
   logic [31:0] rq [7];
   logic        re [7];

   tc4_ctrl u_dut
   (
      .I_REF_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_LOW_FREQ_CLK(lfclk), .I_COUNT_PIN(pin),
      .I_FIRST_CLOCK_SELECT(fsel), .I_FIRST_OVERFLOW(fovf), .I_FIRST_COUNT(fcnt),
      .I_FIRST_PERIOD(fper), .I_FIRST_DUTY(fduty), .O_CASCADE_TICK(ctick),
      .O_FIRST_CLEAR(fclr), .O_MODE16(m16), .O_TIMER_FF(tff), .O_IRQ(irq)
   );

   // 125 MHz reference
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Verdict and end of run
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; an idle edge follows so strobes never toggle twice at once
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1, n < 50);
      if (n >= 50)
         test_done();
      @(posedge clk);
   endtask

   // Bounded wait: 0 interrupt, 1 first clear, 2 flip-flop change
   task automatic wait_on(input int k);
      int n;
      n = 0;
      while (n < 300 && !((k == 0 && irq === 1'b1) || (k == 1 && fclr === 1'b1)
             || (k == 2 && tff !== ff0)))
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("wait", 1, n < 300);
      if (n >= 300)
         test_done();
      @(posedge clk);
   endtask

   task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   // Rising edges on the low-frequency pin (k 1) or the count pin (k 0)
   task automatic pulse(input logic k, input int m);
      repeat (m)
      begin
         if (k)
            lfclk <= 1'b1;
         else
            pin <= 1'b1;
         repeat (4) @(posedge clk);
         lfclk <= 1'b0;
         pin <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask

   initial
   begin
      {rstn, psel, penable, pwrite, lfclk, pin, fovf, paddr, pwdata} = '0;
      {fcnt, fper, fduty} = '0;
      ce = 1'b1;
      fsel = 3'h5;
      ra = '{10'h06c, 10'h074, 10'h07c, 10'h084, 10'h088, 10'h08c, 10'h000};
      rw = '{32'ha2, 32'hffffff5a, 32'ha5, 32'h3, 32'h2, 32'h55, 32'h12};
      rq = '{32'ha2, 32'h5a, 32'ha5, 32'h3, 32'h2, 32'h0, 32'h0};
      re = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      // Write then read back each row, hole and read-only included
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b1, ra[i], rw[i]);
         apb(1'b0, ra[i], 32'h0);
         chk("row data", rq[i], rd);
         chk("row error", re[i], err);
      end
      $display("register rows done");
      // Second reset in mid-run
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc("ctrl reset", 10'h06c, 32'h0);
      rdc("period reset", 10'h074, 32'hff);
      rdc("duty reset", 10'h07c, 32'hff);
      chk("ff reset", 0, tff);
      $display("reset test done");
      // 8-bit timer at fc/2, period 3, then stop keeping the fields
      apb(1'b1, 10'h084, 32'h1);
      apb(1'b1, 10'h074, 32'h3);
      apb(1'b1, 10'h06c, 32'h58);
      wait_on(0);
      rdc("match flag", 10'h080, 32'h1);
      apb(1'b1, 10'h06c, 32'h50);
      rdc("count stop", 10'h08c, 32'h0);
      apb(1'b0, 10'h080, 32'h0);
      chk("irq cleared", 0, irq);
      $display("timer test done");
      // Flip-flop control while stopped
      apb(1'b1, 10'h06c, 32'h80);
      repeat (2) @(posedge clk);
      chk("ff set", 1, tff);
      apb(1'b1, 10'h06c, 32'h00);
      repeat (2) @(posedge clk);
      chk("ff clear", 0, tff);
      // Divider output toggles
      apb(1'b1, 10'h074, 32'h1);
      apb(1'b1, 10'h06c, 32'h59);
      ff0 = tff;
      wait_on(2);
      apb(1'b1, 10'h06c, 32'h51);
      // Reserved mode clears the counter to zero
      apb(1'b1, 10'h06c, 32'h5b);
      repeat (20) @(posedge clk);
      rdc("reserved count", 10'h08c, 32'h0);
      apb(1'b1, 10'h06c, 32'h53);
      $display("mode test done");
      // External pin source, three edges
      apb(1'b1, 10'h074, 32'hff);
      apb(1'b1, 10'h06c, 32'h78);
      pulse(1'b0, 3);
      rdc("pin count", 10'h08c, 32'h3);
      apb(1'b1, 10'h06c, 32'h70);
      // Low-speed mode: prescaler taps dead, low clock and its divide-by-8 alive
      apb(1'b1, 10'h088, 32'h2);
      apb(1'b1, 10'h06c, 32'h38);
      pulse(1'b1, 3);
      rdc("low speed tap", 10'h08c, 32'h0);
      apb(1'b1, 10'h06c, 32'h30);
      apb(1'b1, 10'h06c, 32'h48);
      pulse(1'b1, 3);
      rdc("low clock count", 10'h08c, 32'h3);
      apb(1'b1, 10'h06c, 32'h40);
      apb(1'b1, 10'h06c, 32'h08);
      pulse(1'b1, 8);
      rdc("low clock by 8", 10'h08c, 32'h1);
      apb(1'b1, 10'h06c, 32'h00);
      apb(1'b1, 10'h088, 32'h0);
      $display("clock source test done");
      // 8-bit PWM on the undivided clock, duty rewritten while running
      apb(1'b1, 10'h084, 32'h2);
      apb(1'b1, 10'h07c, 32'h2);
      ff0 = tff;
      apb(1'b1, 10'h06c, 32'h6a);
      wait_on(2);
      apb(1'b1, 10'h07c, 32'h10);
      wait_on(0);
      rdc("pwm flags", 10'h080, 32'h3);
      apb(1'b1, 10'h06c, 32'h62);
      rdc("pwm duty", 10'h07c, 32'h10);
      apb(1'b0, 10'h080, 32'h0);
      $display("pwm test done");
      // Cascade: 16-bit match at zero clears the first timer
      apb(1'b1, 10'h074, 32'h0);
      apb(1'b1, 10'h06c, 32'h0c);
      chk("mode16", 1, m16);
      wait_on(1);
      apb(1'b1, 10'h06c, 32'h04);
      // Warm-up: first timer overflow clocks the high byte, own clock ignored
      apb(1'b1, 10'h074, 32'hff);
      apb(1'b1, 10'h06c, 32'h5d);
      repeat (2)
      begin
         fovf <= 1'b1;
         @(posedge clk);
         fovf <= 1'b0;
         @(posedge clk);
      end
      rdc("overflow count", 10'h08c, 32'h2);
      apb(1'b1, 10'h06c, 32'h55);
      // 16-bit PWM: duty match takes the first timer byte as low half
      fduty <= 8'h05;
      fcnt <= 8'h05;
      apb(1'b1, 10'h07c, 32'h0);
      ff0 = tff;
      apb(1'b1, 10'h06c, 32'h0e);
      wait_on(2);
      apb(1'b1, 10'h06c, 32'h06);
      $display("cascade test done");
      test_done();
   end
endmodule
